/* File: logic/apm_power_seq.sv */
// Power-management sequencer of a serial sampling converter
// Contract
// R1 - Power state chosen from two-bit software field plus sleep pin level.
// R2 - Full down: all circuits off; partial down keeps reference on.
// R3 - 00: pin low between-conv down, high up; 01 normal, 10 down, 11 partial.
// R4 - Power field resets to zero; host keeps zero when using sleep pin.
// R5 - Field zero with sleep high never powers down.
// R6 - Host holds sleep low for low-throughput between-conversion power-down.
// R7 - Software-only host ties sleep high and uses the field.
// R8 - Sleep ignored and no power-down until power-up calibration finishes.
// R9 - Host idles about 42 ms after supply power-up with autocalibration.
// R10 - Calibrate pin high disables autocalibration; host waits power-up time.
// R11 - Ready for operation 5 us after wake from full power-down.
// R12 - Host limits throughput with between-conversion power-down.
// R13 - Between-conversion modes power down when busy falls.
// R14 - Falling edge of conversion start wakes from between-conversion down.
// R15 - Host holds conversion start low at least 5 us on wake.
// R16 - Host wakes with a separate 01 write before software conversion.
// R17 - No automatic partial power-down after calibration.
// R18 - Host uses three writes per calibration cycle in partial mode.
// R19 - Host uses partial down before long idle with internal reference.
// R20 - Busy high from calibration start until calibration completes.
// R21 - State re-evaluated each clock from registered field and synced pin.
// R22 - Wake delay is a cycle counter reaching at least the wake time.
`default_nettype none
module apm_power_seq (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic field_wr,
	input wire logic [1:0] field_wdata,
	input wire logic software_calibrate_bit,
	input wire logic sleep_n_pin,
	input wire logic conversion_start_pin,
	input wire logic cal_n_pin,
	input wire logic cal_done,
	input wire logic conv_done,
	output logic [1:0] power_field,
	output logic core_power_on,
	output logic ref_power_on,
	output logic ready,
	output logic conv_go,
	output logic cal_go,
	output logic busy,
	output logic [2:0] power_mode
);
	import apm_pkg::*;

	logic sleep_n_s;
	logic conversion_start_pin_s;
	logic cal_n_s;
	logic conversion_start_pin_d_r;
	logic conversion_start_pin_d_nxt;
	logic cal_n_d_r;
	logic cal_n_d_nxt;
	logic [1:0] field_r;
	logic [1:0] field_nxt;
	apm_state_t state_r;
	apm_state_t state_nxt;
	logic [APM_WAKE_W-1:0] wake_cnt_r;
	logic [APM_WAKE_W-1:0] wake_cnt_nxt;
	logic init_cal_seen_r;
	logic init_cal_seen_nxt;
	// Settle count: synced pins are stale for two edges after release
	logic [1:0] settle_r;
	logic [1:0] settle_nxt;
	apm_mode_t mode;
	logic conversion_start_pin_fall;
	logic conversion_start_pin_rise;
	logic cal_rise;
	logic cal_req;

	// Mode decode, used for both current and next state choices
	function automatic apm_mode_t mode_of(input logic [1:0] f, input logic sl_n);
		apm_mode_t m;
		m = APM_MODE_NORMAL;
		case (f)
			APM_PF_SLEEP_CTL: m = sl_n ? APM_MODE_FULL_UP : APM_MODE_FULL_BETWEEN; // see R3 see R5
			APM_PF_NORMAL: m = APM_MODE_NORMAL;
			APM_PF_FULL_DOWN: m = APM_MODE_FULL_DOWN;
			APM_PF_PARTIAL_BETWEEN: m = APM_MODE_PARTIAL_BETWEEN;
			default: m = APM_MODE_NORMAL;
		endcase
		return m;
	endfunction

	function automatic logic is_between(input apm_mode_t m);
		return (m == APM_MODE_FULL_BETWEEN) || (m == APM_MODE_PARTIAL_BETWEEN);
	endfunction

	// Pins cross into the clock domain before any logic looks at them
	apm_sync u_sync_sleep (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(sleep_n_pin),
		.pin_sync(sleep_n_s)
	);
	apm_sync u_sync_conversion_start_pin (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(conversion_start_pin),
		.pin_sync(conversion_start_pin_s)
	);
	apm_sync u_sync_cal (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(cal_n_pin),
		.pin_sync(cal_n_s)
	);

	// Edge detectors read only the second synchroniser flop
	assign conversion_start_pin_fall = conversion_start_pin_d_r & ~conversion_start_pin_s;
	assign conversion_start_pin_rise = ~conversion_start_pin_d_r & conversion_start_pin_s;
	assign cal_rise = ~cal_n_d_r & cal_n_s;
	assign cal_req = cal_rise | software_calibrate_bit;
	assign mode = mode_of(field_r, sleep_n_s); // see R1 see R21

	// Next-state logic of the sequencer
	always_comb begin
		conversion_start_pin_d_nxt = conversion_start_pin_s;
		cal_n_d_nxt = cal_n_s;
		field_nxt = field_wr ? field_wdata : field_r; // see R1
		state_nxt = state_r;
		wake_cnt_nxt = wake_cnt_r;
		init_cal_seen_nxt = init_cal_seen_r;
		settle_nxt = settle_r;
		case (state_r)
			APM_ST_INIT_CAL: begin
				// Sleep pin has no say here; held on until calibration ends
				if (settle_r != 2'(APM_SYNC_SETTLE)) begin
					// Calibrate pin not yet through the synchroniser; judging
					// now would always read the reset value and skip autocal
					settle_nxt = settle_r + 2'h1; // see R8
				end else if (cal_n_s && !init_cal_seen_r) begin
					// Calibrate pin high at release: autocalibration disabled
					state_nxt = APM_ST_ON; // see R10
				end else if (!cal_n_s) begin
					init_cal_seen_nxt = 1'b1;
				end else if (cal_done) begin
					state_nxt = APM_ST_ON; // see R8
				end
			end
			APM_ST_ON: begin
				if (cal_req) begin
					state_nxt = APM_ST_CAL; // see R20
				end else if (mode == APM_MODE_FULL_DOWN) begin
					state_nxt = APM_ST_DOWN;
				end else if (conversion_start_pin_rise) begin
					state_nxt = APM_ST_CONVERT;
				end
			end
			APM_ST_CONVERT: begin
				if (conv_done) begin
					// Busy falls here; between modes drop straight to down
					state_nxt = is_between(mode) ? APM_ST_DOWN : APM_ST_ON; // see R13
				end
			end
			APM_ST_CAL: begin
				// Calibration end always returns on: partial down waits for the next conversion end
				if (cal_done) begin
					state_nxt = APM_ST_ON; // see R17
				end
			end
			APM_ST_DOWN: begin
				wake_cnt_nxt = '0;
				if (cal_req || (is_between(mode) && conversion_start_pin_fall) || mode == APM_MODE_NORMAL
						|| mode == APM_MODE_FULL_UP) begin
					state_nxt = APM_ST_WAKE; // see R14
				end
			end
			APM_ST_WAKE: begin
				// Counter covers the rounded-up wake time before ready
				if (wake_cnt_r >= APM_WAKE_W'(APM_WAKE_CYCLES - 1)) begin
					state_nxt = APM_ST_ON; // see R11 see R22
				end else begin
					wake_cnt_nxt = wake_cnt_r + APM_WAKE_W'(1);
				end
			end
			default: state_nxt = APM_ST_INIT_CAL;
		endcase
	end

	// Registers; field clears to zero on reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			field_r <= APM_PF_RESET; // see R4
			state_r <= APM_ST_INIT_CAL;
			wake_cnt_r <= '0;
			init_cal_seen_r <= 1'b0;
			settle_r <= 2'h0;
			conversion_start_pin_d_r <= 1'b1;
			cal_n_d_r <= 1'b1;
		end else begin
			field_r <= field_nxt;
			state_r <= state_nxt;
			wake_cnt_r <= wake_cnt_nxt;
			init_cal_seen_r <= init_cal_seen_nxt;
			settle_r <= settle_nxt;
			conversion_start_pin_d_r <= conversion_start_pin_d_nxt;
			cal_n_d_r <= cal_n_d_nxt;
		end
	end

	// Output decode per state; rails drop only in the down state
	always_comb begin
		core_power_on = 1'b1;
		ref_power_on = 1'b1;
		ready = 1'b0;
		busy = 1'b0;
		case (state_r)
			APM_ST_INIT_CAL: begin
				// Busy only once the calibrate pin was seen low
				busy = init_cal_seen_r; // see R20
			end
			APM_ST_ON: begin
				ready = 1'b1;
			end
			APM_ST_CONVERT: begin
				busy = 1'b1;
			end
			APM_ST_CAL: begin
				busy = 1'b1; // see R20
			end
			APM_ST_DOWN: begin
				// Partial mode keeps the reference usable from outside
				core_power_on = 1'b0; // see R2
				ref_power_on = (mode == APM_MODE_PARTIAL_BETWEEN); // see R2
			end
			APM_ST_WAKE: begin
				// Rails back on while the wake counter runs; not yet ready
				ready = 1'b0;
			end
			default: begin
				ready = 1'b0;
			end
		endcase
	end

	// Start strobes; a calibrate request outranks a conversion start
	always_comb begin
		conv_go = 1'b0;
		cal_go = 1'b0;
		if (state_r == APM_ST_ON) begin
			cal_go = cal_req; // see R20
			conv_go = conversion_start_pin_rise && !cal_req && (mode != APM_MODE_FULL_DOWN);
		end else if (state_r == APM_ST_INIT_CAL && init_cal_seen_r) begin
			// Autocalibration starts as the calibrate pin comes back high
			cal_go = cal_rise; // see R8
		end
	end
	assign power_field = field_r;
	assign power_mode = mode;
endmodule // apm_power_seq
`default_nettype wire

/* File: logic/apm_pkg.sv */
// Package of constants and types for the converter power sequencer
`default_nettype none
package apm_pkg;
	// Power field encodings
	localparam logic [1:0] APM_PF_SLEEP_CTL = 2'h0;
	localparam logic [1:0] APM_PF_NORMAL = 2'h1;
	localparam logic [1:0] APM_PF_FULL_DOWN = 2'h2;
	localparam logic [1:0] APM_PF_PARTIAL_BETWEEN = 2'h3;
	localparam logic [1:0] APM_PF_RESET = 2'h0;
	localparam int APM_PF_HIGH_BIT = 1;
	localparam int APM_PF_LOW_BIT = 0;
	// Timing
	localparam int APM_CLK_MHZ = 250;
	localparam int APM_WAKE_NS = 5000;
	localparam int APM_WAKE_CYCLES = (APM_WAKE_NS * APM_CLK_MHZ + 999) / 1000;
	localparam int APM_WAKE_W = 11;
	// Cycles for a pin to reach the second synchroniser flop after reset
	localparam int APM_SYNC_SETTLE = 2;
	// Selected power mode
	typedef enum logic [2:0] {
		APM_MODE_FULL_UP = 3'b000,
		APM_MODE_NORMAL = 3'b001,
		APM_MODE_FULL_DOWN = 3'b010,
		APM_MODE_FULL_BETWEEN = 3'b011,
		APM_MODE_PARTIAL_BETWEEN = 3'b100
	} apm_mode_t;
	// Sequencer state
	typedef enum logic [2:0] {
		APM_ST_INIT_CAL = 3'b000,
		APM_ST_ON = 3'b001,
		APM_ST_DOWN = 3'b010,
		APM_ST_WAKE = 3'b011,
		APM_ST_CONVERT = 3'b100,
		APM_ST_CAL = 3'b101
	} apm_state_t;
endpackage : apm_pkg
`default_nettype wire

/* File: logic/apm_sync.sv */
// Two-flop synchroniser for pin inputs
`default_nettype none
module apm_sync (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pin_in,
	output logic pin_sync
);
	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;
	// First flop only feeds the second
	always_comb begin
		meta_nxt = pin_in;
		sync_nxt = meta_r;
	end
	// Pins idle high; reset high so no false edge follows release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end
	assign pin_sync = sync_r;
endmodule // apm_sync
`default_nettype wire

/* File: verif/apm_core_model.sv */
// Behavioural conversion and calibration core facing the sequencer
`default_nettype none
module apm_core_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic conv_go,
	input wire logic cal_go,
	input wire logic slow,
	output logic conv_done,
	output logic cal_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cnt_r;
	logic act_r;
	logic cal_r;
	// One job at a time; slow makes calibration outlast short waits
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{cnt_r, act_r, cal_r, conv_done, cal_done} <= '0;
		end else begin
			conv_done <= act_r && cnt_r == 6'h0 && !cal_r;
			cal_done <= act_r && cnt_r == 6'h0 && cal_r;
			if (conv_go || cal_go) begin
				{act_r, cal_r} <= {1'b1, cal_go};
				cnt_r <= slow ? 6'h28 : 6'h3;
			end else if (act_r) begin
				act_r <= cnt_r != 6'h0;
				cnt_r <= cnt_r - 6'h1;
			end
		end
	end
endmodule // apm_core_model
`default_nettype wire

/* File: verif/apm_sva.sv */
// Port checker for the power sequencer
`default_nettype none
module apm_sva
	import apm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic field_wr,
	input wire logic [1:0] field_wdata,
	input wire logic conversion_start_pin,
	input wire logic cal_done,
	input wire logic conv_done,
	input wire logic [1:0] power_field,
	input wire logic core_power_on,
	input wire logic ref_power_on,
	input wire logic ready,
	input wire logic busy,
	input wire logic conv_go,
	input wire logic cal_go,
	input wire logic [2:0] power_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	localparam int WLO = 1245;
	localparam int WHI = 1253;
	// Powered, not-ready cycles since the last down spell; a range this long is too slow to unroll
	logic [10:0] up_cnt_r;
	logic woke_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			up_cnt_r <= 11'h000;
			woke_r <= 1'b0;
		end else if (!core_power_on) begin
			up_cnt_r <= 11'h000;
			woke_r <= 1'b1;
		end else if (ready) begin
			woke_r <= 1'b0;
		end else if (up_cnt_r != 11'h7FF) begin
			up_cnt_r <= up_cnt_r + 11'h001;
		end
	end
	// Between-conversion modes, full or partial
	wire logic btw = power_mode == APM_MODE_FULL_BETWEEN || power_mode == APM_MODE_PARTIAL_BETWEEN;
	sequence s_wake_done;
		woke_r && $rose(ready);
	endsequence
	AST_FIELD_LOAD: assert property (field_wr |=> power_field == $past(field_wdata))
		else $error("power field not loaded");
	AST_MODE_MAP: assert property (power_field != 2'h0 |-> power_mode ==
		(power_field == 2'h1 ? APM_MODE_NORMAL : power_field == 2'h2 ? APM_MODE_FULL_DOWN :
		APM_MODE_PARTIAL_BETWEEN)) else $error("mode decode wrong");
	AST_REF_KEEP: assert property (!core_power_on && power_mode == APM_MODE_PARTIAL_BETWEEN
		|-> ref_power_on) else $error("reference off in partial down");
	AST_NO_SLEEP: assert property (power_mode == APM_MODE_FULL_UP [*3] |-> core_power_on)
		else $error("powered down in full up");
	AST_BUSY_POWER: assert property (busy |-> core_power_on)
		else $error("down while busy");
	AST_AUTO_DOWN: assert property (conv_done && busy && btw |=> !busy && !core_power_on)
		else $error("no power down after conversion");
	AST_CAL_UP: assert property (cal_done && busy |=> !busy && core_power_on)
		else $error("calibration end wrong");
	AST_WAKE_EDGE: assert property (!core_power_on && btw && $fell(conversion_start_pin)
		|-> ##[1:4] core_power_on) else $error("start fall did not wake");
	AST_WAKE_TIME: assert property (s_wake_done |-> up_cnt_r >= 11'(WLO) && up_cnt_r <= 11'(WHI))
		else $error("wake time wrong");
	AST_CONV_BUSY: assert property (conv_go |=> busy)
		else $error("no busy after conversion start");
	AST_CAL_BUSY: assert property (cal_go |=> busy)
		else $error("no busy after calibration start");
endmodule // apm_sva
bind apm_power_seq apm_sva chk (.core_clk, .rst, .field_wr, .field_wdata, .conversion_start_pin,
	.cal_done, .conv_done, .power_field, .core_power_on, .ref_power_on, .ready, .busy, .conv_go,
	.cal_go, .power_mode);
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the power sequencer
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import apm_pkg::*;
	logic core_clk, rst, field_wr, software_calibrate_bit, sleep_n_pin, conversion_start_pin;
	logic cal_n_pin, cal_done, conv_done, slow, core_power_on, ref_power_on, ready;
	logic conv_go, cal_go, busy;
	logic [1:0] field_wdata, power_field;
	logic [2:0] power_mode;
	int bad_count, comparisons, seed, i;
	initial begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end
	apm_power_seq uut (.core_clk, .rst, .field_wr, .field_wdata, .software_calibrate_bit,
		.sleep_n_pin, .conversion_start_pin, .cal_n_pin, .cal_done, .conv_done, .power_field,
		.core_power_on, .ref_power_on, .ready, .conv_go, .cal_go, .busy, .power_mode);
	apm_core_model core (.core_clk, .rst, .conv_go, .cal_go, .slow, .conv_done, .cal_done);
	// Expected mode from field and settled sleep level
	function automatic apm_mode_t exp_mode(logic [1:0] f, logic s);
		exp_mode = f == 2'h0 ? (s ? APM_MODE_FULL_UP : APM_MODE_FULL_BETWEEN) :
			f == 2'h1 ? APM_MODE_NORMAL : f == 2'h2 ? APM_MODE_FULL_DOWN : APM_MODE_PARTIAL_BETWEEN;
	endfunction
	task automatic wr(logic [1:0] f);
		@(negedge core_clk);
		{field_wr, field_wdata} = {1'b1, f};
		@(negedge core_clk);
		field_wr = 0;
		`CHK(power_field, f)
		`CHK(power_mode, exp_mode(f, sleep_n_pin))
	endtask
	task automatic wait_ready();
		repeat (1400) if (ready !== 1'b1) @(negedge core_clk);
	endtask
	// Start pulse held low h cycles, then wait out the conversion
	task automatic conv(int h);
		@(negedge core_clk);
		conversion_start_pin = 0;
		repeat (h) @(negedge core_clk);
		conversion_start_pin = 1;
		repeat (6) @(negedge core_clk);
		repeat (200) if (busy === 1'b1) @(negedge core_clk);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		close_out();
	end
	initial begin
		{seed, rst, field_wr, field_wdata, software_calibrate_bit, slow} = {32'd16024, 6'h20};
		{sleep_n_pin, conversion_start_pin, cal_n_pin, bad_count, comparisons} = '1;
		{bad_count, comparisons} = '0;
		repeat (6) @(negedge core_clk);
		rst = 0;
		wait_ready();
		`CHK(power_field, 2'h0)
		`CHK(busy, 1'b0)
		// Random field writes, sleep tied high for software control
		for (i = 0; i < 12; i++) wr(2'($random(seed)));
		wr(2'h1);
		wait_ready();
		`CHK(ready, 1'b1)
		$display("test 1 done");
		// Sleep-pin between mode, then partial between mode
		for (i = 0; i < 2; i++) begin
			sleep_n_pin = i[0];
			repeat (3) @(negedge core_clk);
			wr(i[0] ? 2'h3 : 2'h0);
			conv(3);
			`CHK(core_power_on, 1'b0)
			`CHK(ref_power_on, i[0])
			conv(1300);
			`CHK(core_power_on, 1'b0)
			wr(2'h1);
			wait_ready();
		end
		$display("test 2 done");
		// Slow calibration in partial mode must end powered up
		slow = 1;
		wr(2'h3);
		software_calibrate_bit = 1;
		@(negedge core_clk);
		software_calibrate_bit = 0;
		repeat (80) if (busy === 1'b1) @(negedge core_clk);
		`CHK(core_power_on, 1'b1)
		slow = 0;
		conv(3);
		`CHK(ref_power_on, 1'b1)
		`CHK(core_power_on, 1'b0)
		wr(2'h1);
		wait_ready();
		wr(2'h0);
		conv(3);
		`CHK(core_power_on, 1'b1)
		$display("test 3 done");
		// Second reset with calibrate pin low: autocal, sleep low ignored
		@(negedge core_clk);
		{rst, cal_n_pin, sleep_n_pin} = 3'h4;
		repeat (6) @(negedge core_clk);
		rst = 0;
		repeat (20) @(negedge core_clk);
		`CHK(busy, 1'b1)
		`CHK(core_power_on, 1'b1)
		cal_n_pin = 1;
		repeat (4) @(negedge core_clk);
		repeat (200) if (busy === 1'b1) @(negedge core_clk);
		`CHK(ready, 1'b1)
		`CHK(power_field, 2'h0)
		conv(3);
		`CHK(core_power_on, 1'b0)
		$display("test 4 done");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
